// ==== rtl/hcl_loader.sv ====
`timescale 1ns/100ps
`include "hcl_defines.svh"
module hcl_loader
   import hcl_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic two_byte_addr,
   input wire logic fuse_present,
   input wire logic [15:0] fuse_vendor_identifier,
   input wire logic [15:0] fuse_product_identifier,
   input wire logic [7:0] fuse_device_release_identifier,
   input wire logic high_speed,
   input wire logic mem_miso,
   output logic mem_cs_n,
   output logic mem_sck,
   output logic mem_mosi,
   output logic load_done,
   output logic vendor_class,
   output logic [15:0] vendor_identifier,
   output logic [15:0] product_identifier,
   output logic [7:0] device_release_identifier,
   output logic [3:0] enabled_port_oc_filter,
   output logic [3:0] disabled_port_oc_filter,
   output logic [3:0] usable_port_mask,
   output logic [2:0] port_count,
   output logic [7:0] detachable_port_mask,
   output logic [3:0] physical_of_logical_1,
   output logic [3:0] physical_of_logical_2,
   output logic [3:0] physical_of_logical_3,
   output logic [3:0] physical_of_logical_4,
   output logic [7:0] upstream_draw_limit,
   output logic [7:0] controller_current_figure,
   output logic [7:0] port_power_settle_time,
   output logic accept_zero_descriptor_type,
   output logic part_of_composite_flag,
   output logic limit_to_12mbit,
   output logic indicators_off_flag,
   output logic shared_power_switch_flag,
   output logic [15:0] hub_characteristics
);

   // popcount of the usable mask
   function automatic logic [2:0] hcl_ones(input logic [3:0] m);
      hcl_ones = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]};
   endfunction : hcl_ones

   // physical port (1-based) that serves a logical slot, zero if none
   function automatic logic [3:0] hcl_phys(input logic [3:0] m, input logic [2:0] slot);
      logic [2:0] seen;
      seen = 3'b000;
      hcl_phys = 4'h_0;
      for (int i = 0; i < 4; i++) begin
         if (m[i]) begin
            seen = seen + 3'b001;
            if (seen == slot && hcl_phys == 4'h_0) begin
               hcl_phys = 4'(i + 1);
            end
         end
      end
   endfunction : hcl_phys

   hcl_state_t state;
   logic [3:0] div_cnt;
   logic [4:0] bit_cnt;
   logic [23:0] shreg;
   logic [7:0] rx;
   logic [3:0] addr;
   logic [3:0] img_len;
   logic all_blank;
   logic [7:0] img [0:12];
   logic miso_meta;
   logic miso_sync;
   logic fs_meta;
   logic fs_sync;
   logic sck_int;
   logic addr2_meta;
   logic addr2_sync;
   logic hs_meta;
   logic hs_sync;
   logic [1:0] warm;

   wire tick = (div_cnt == `HCL_HALF_DIV - 4'h_1);
   wire rise = tick && !sck_int;
   wire fall = tick && sck_int;
   // ninth address bit folds into the command for one-byte parts; here always zero
   wire [7:0] cmd_byte = `HCL_CMD_READ;
   wire [4:0] addr_bits = addr2_sync ? 5'd16 : 5'd8;
   wire [23:0] cmd_frame = addr2_sync ? {cmd_byte, 12'h_000, addr} : {cmd_byte, 4'h_0, addr, 8'h_00};
   wire is_ext = (img[0] == `HCL_HDR_EXT);
   wire is_ident = (img[0] == `HCL_HDR_IDENT);
   wire [7:0] next_rx = {rx[6:0], miso_sync};

   // 2-flop synchronisers; only the second stage is read
   // straps and the speed level come from outside this clock, so they pass two flops too
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         miso_meta <= 1'b0;
         miso_sync <= 1'b0;
         fs_meta <= 1'b0;
         fs_sync <= 1'b0;
         addr2_meta <= 1'b0;
         addr2_sync <= 1'b0;
         hs_meta <= 1'b0;
         hs_sync <= 1'b0;
      end else begin
         miso_meta <= mem_miso;
         miso_sync <= miso_meta;
         fs_meta <= fuse_present;
         fs_sync <= fs_meta;
         addr2_meta <= two_byte_addr;
         addr2_sync <= addr2_meta;
         hs_meta <= high_speed;
         hs_sync <= hs_meta;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_cnt <= 4'h_0;
      end else if (tick || state == HCL_IDLE || state == HCL_DONE) begin
         div_cnt <= 4'h_0;
      end else begin
         div_cnt <= div_cnt + 4'h_1;
      end
   end

   // one read transaction per byte; slower than streaming but keeps decoding simple
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= HCL_IDLE;
         bit_cnt <= 5'd0;
         shreg <= 24'h_0000_00;
         rx <= 8'h_00;
         addr <= 4'h_0;
         img_len <= `HCL_LEN_IDENT;
         all_blank <= 1'b1;
         sck_int <= 1'b0;
         warm <= 2'h_0;
         mem_cs_n <= 1'b1;
         mem_mosi <= 1'b0;
         load_done <= 1'b0;
      end else begin
         unique case (state)
            HCL_IDLE: begin
               // the fuse strap is trusted only once its synchroniser has settled
               if (warm != 2'h_2) begin
                  warm <= warm + 2'h_1;
               end else if (fs_sync) begin
                  // fuse rom makes the external memory unnecessary
                  state <= HCL_DONE;
                  load_done <= 1'b1;
               end else begin
                  mem_cs_n <= 1'b0;
                  shreg <= cmd_frame;
                  mem_mosi <= cmd_frame[23];
                  bit_cnt <= 5'd7;
                  state <= HCL_CMD;
               end
            end
            HCL_CMD, HCL_ADDR: begin
               if (tick) begin
                  sck_int <= !sck_int;
               end
               if (fall) begin
                  shreg <= {shreg[22:0], 1'b0};
                  mem_mosi <= shreg[22];
                  if (bit_cnt == 5'd0) begin
                     if (state == HCL_CMD) begin
                        state <= HCL_ADDR;
                        bit_cnt <= addr_bits - 5'd1;
                     end else begin
                        state <= HCL_DATA;
                        bit_cnt <= 5'd7;
                     end
                  end else begin
                     bit_cnt <= bit_cnt - 5'd1;
                  end
               end
            end
            HCL_DATA: begin
               if (tick) begin
                  sck_int <= !sck_int;
               end
               if (rise) begin
                  rx <= next_rx;
               end
               if (fall) begin
                  if (bit_cnt == 5'd0) begin
                     state <= HCL_STORE;
                  end else begin
                     bit_cnt <= bit_cnt - 5'd1;
                  end
               end
            end
            HCL_STORE: begin
               mem_cs_n <= 1'b1;
               if (rx != `HCL_BLANK) begin
                  all_blank <= 1'b0;
               end
               // header picks the length of the image that follows
               if (addr == 4'h_0) begin
                  img_len <= (rx == `HCL_HDR_EXT) ? `HCL_LEN_EXT : `HCL_LEN_IDENT;
               end
               state <= HCL_NEXT;
            end
            HCL_NEXT: begin
               // ascending byte order; blank or unknown headers stop after byte 0
               if (addr + 4'h_1 < img_len && (addr != 4'h_0 || img[0] == `HCL_HDR_EXT
                     || img[0] == `HCL_HDR_IDENT)) begin
                  addr <= addr + 4'h_1;
                  state <= HCL_IDLE;
               end else begin
                  state <= HCL_DONE;
                  load_done <= 1'b1;
               end
            end
            HCL_DONE: begin
               // image is latched until the next reset
               load_done <= 1'b1;
            end
            default: begin
               state <= HCL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (state == HCL_STORE) begin
         img[addr] <= rx;
      end
   end

   // decoded settings, defaults unless an extended image supplies them
   wire use_ext = !fs_sync && is_ext;
   wire use_ids = !fs_sync && (is_ext || is_ident);
   wire [7:0] b_oc = use_ext ? img[`HCL_BYTE_OC] : `HCL_DEF_OC;
   wire [7:0] b_ports = use_ext ? img[`HCL_BYTE_PORTS] : `HCL_DEF_PORTS;
   wire [7:0] b_draw = use_ext ? img[`HCL_BYTE_DRAW] : (hs_sync ? `HCL_DEF_DRAW_HS : `HCL_DEF_DRAW_FS);
   wire [7:0] b_ctrl = use_ext ? img[`HCL_BYTE_CTRL] : (hs_sync ? `HCL_DEF_CTRL_HS : `HCL_DEF_CTRL_FS);
   wire [7:0] b_settle = use_ext ? img[`HCL_BYTE_SETTLE] : `HCL_DEF_SETTLE;
   // reserved bits are expected zero from the programmer and are ignored here
   wire [7:0] b_flags = use_ext ? img[`HCL_BYTE_FLAGS] : `HCL_DEF_FLAGS;
   wire gang = b_flags[`HCL_FLAG_GANG];
   wire [1:0] pwr_mode = gang ? 2'b00 : 2'b01;
   wire [1:0] oc_mode = gang ? 2'b00 : 2'b01;
   wire [15:0] next_chars = {8'h_00, !b_flags[`HCL_FLAG_NO_IND], 2'b00, oc_mode,
                             b_flags[`HCL_FLAG_COMPOSITE], pwr_mode};

   // identity and class settle once the load has finished
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vendor_class <= 1'b0;
         vendor_identifier <= `HCL_DEF_VID;
         product_identifier <= `HCL_DEF_PID;
         device_release_identifier <= `HCL_DEF_DID;
      end else if (state == HCL_DONE) begin
         vendor_class <= !fs_sync && all_blank;
         vendor_identifier <= fs_sync ? fuse_vendor_identifier
                              : (use_ids ? {img[2], img[1]} : `HCL_DEF_VID);
         product_identifier <= fs_sync ? fuse_product_identifier
                               : (use_ids ? {img[4], img[3]} : `HCL_DEF_PID);
         device_release_identifier <= fs_sync ? fuse_device_release_identifier
                                      : (use_ids ? img[6] : `HCL_DEF_DID);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enabled_port_oc_filter <= 4'h_0;
         disabled_port_oc_filter <= 4'h_0;
         usable_port_mask <= 4'h_0;
         port_count <= 3'd0;
         detachable_port_mask <= 8'h_00;
         physical_of_logical_1 <= 4'h_0;
         physical_of_logical_2 <= 4'h_0;
         physical_of_logical_3 <= 4'h_0;
         physical_of_logical_4 <= 4'h_0;
      end else if (state == HCL_DONE) begin
         enabled_port_oc_filter <= b_oc[7:4];
         disabled_port_oc_filter <= b_oc[3:0];
         usable_port_mask <= b_ports[7:4];
         port_count <= hcl_ones(b_ports[7:4]);
         // descriptor bit 0 is reserved, logical port n sits at bit n
         detachable_port_mask <= {3'b000, b_ports[3:0], 1'b0};
         physical_of_logical_1 <= hcl_phys(b_ports[7:4], 3'd1);
         physical_of_logical_2 <= hcl_phys(b_ports[7:4], 3'd2);
         physical_of_logical_3 <= hcl_phys(b_ports[7:4], 3'd3);
         physical_of_logical_4 <= hcl_phys(b_ports[7:4], 3'd4);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         upstream_draw_limit <= 8'h_00;
         controller_current_figure <= 8'h_00;
         port_power_settle_time <= 8'h_00;
         accept_zero_descriptor_type <= 1'b0;
         part_of_composite_flag <= 1'b0;
         limit_to_12mbit <= 1'b0;
         indicators_off_flag <= 1'b0;
         shared_power_switch_flag <= 1'b0;
         hub_characteristics <= 16'h_0000;
      end else if (state == HCL_DONE) begin
         upstream_draw_limit <= b_draw;
         controller_current_figure <= b_ctrl;
         port_power_settle_time <= b_settle;
         accept_zero_descriptor_type <= b_flags[`HCL_FLAG_ZERO_DESC];
         part_of_composite_flag <= b_flags[`HCL_FLAG_COMPOSITE];
         limit_to_12mbit <= b_flags[`HCL_FLAG_FS_ONLY];
         indicators_off_flag <= b_flags[`HCL_FLAG_NO_IND];
         shared_power_switch_flag <= gang;
         hub_characteristics <= next_chars;
      end
   end

   assign mem_sck = sck_int;

endmodule : hcl_loader

// ==== rtl/hcl_defines.svh ====
`ifndef HCL_DEFINES_SVH
`define HCL_DEFINES_SVH
`define HCL_HDR_IDENT 8'h_D0
`define HCL_HDR_EXT 8'h_D2
`define HCL_BLANK 8'h_FF
`define HCL_LEN_IDENT 4'h_7
`define HCL_LEN_EXT 4'h_D
`define HCL_BYTE_OC 4'h_7
`define HCL_BYTE_PORTS 4'h_8
`define HCL_BYTE_DRAW 4'h_9
`define HCL_BYTE_CTRL 4'h_A
`define HCL_BYTE_SETTLE 4'h_B
`define HCL_BYTE_FLAGS 4'h_C
`define HCL_DEF_OC 8'h_88
`define HCL_DEF_PORTS 8'h_FF
`define HCL_DEF_DRAW_FS 8'h_28
`define HCL_DEF_DRAW_HS 8'h_57
`define HCL_DEF_CTRL_FS 8'h_50
`define HCL_DEF_CTRL_HS 8'h_AE
`define HCL_DEF_SETTLE 8'h_32
`define HCL_DEF_FLAGS 8'h_80
`define HCL_FLAG_ZERO_DESC 7
`define HCL_FLAG_COMPOSITE 6
`define HCL_FLAG_FS_ONLY 5
`define HCL_FLAG_NO_IND 4
`define HCL_FLAG_GANG 2
`define HCL_CMD_READ 8'h_03
`define HCL_A8_POS 3
`define HCL_HALF_DIV 4'h_4
`define HCL_DEF_VID 16'h_0000
`define HCL_DEF_PID 16'h_0000
`define HCL_DEF_DID 8'h_00
`endif

// ==== rtl/hcl_pkg.sv ====
package hcl_pkg;
   typedef enum logic [3:0] {
      HCL_IDLE = 4'h_0,
      HCL_CMD = 4'h_1,
      HCL_ADDR = 4'h_3,
      HCL_DATA = 4'h_2,
      HCL_STORE = 4'h_6,
      HCL_NEXT = 4'h_7,
      HCL_DONE = 4'h_5
   } hcl_state_t;
endpackage : hcl_pkg

// ==== verification/hcl_loader_sva.sv ====
`timescale 1ns/100ps
module hcl_loader_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic mem_cs_n,
   input wire logic mem_sck,
   input wire logic load_done,
   input wire logic [15:0] vendor_identifier,
   input wire logic [3:0] usable_port_mask,
   input wire logic [2:0] port_count,
   input wire logic [3:0] physical_of_logical_1,
   input wire logic part_of_composite_flag,
   input wire logic indicators_off_flag,
   input wire logic shared_power_switch_flag,
   input wire logic [15:0] hub_characteristics
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_settled; load_done ##1 load_done; endsequence
   sequence s_sck_high; mem_sck [*4] ##1 !mem_sck; endsequence
   property p_sck_half; $rose(mem_sck) |-> s_sck_high; endproperty
   a_sck_half: assert property (p_sck_half) else $error("sck half period wrong");
   property p_sck_select; $fell(mem_cs_n) |-> !mem_sck; endproperty
   a_sck_select: assert property (p_sck_select) else $error("sck high at select");
   property p_gap; $rose(mem_cs_n) |=> mem_cs_n; endproperty
   a_gap: assert property (p_gap) else $error("select gap too short");
   property p_done_hold; load_done |=> load_done; endproperty
   a_done_hold: assert property (p_done_hold) else $error("load done dropped");
   property p_quiet; load_done |-> mem_cs_n; endproperty
   a_quiet: assert property (p_quiet) else $error("memory selected after load");
   property p_id_stable; s_settled |=> $stable(vendor_identifier); endproperty
   a_id_stable: assert property (p_id_stable) else $error("identifier changed after load");
   property p_count; s_settled |-> port_count == 3'($countones(usable_port_mask)); endproperty
   a_count: assert property (p_count) else $error("port count mismatch");
   property p_map1; s_settled ##0 usable_port_mask[0] |-> physical_of_logical_1 == 4'h_1; endproperty
   a_map1: assert property (p_map1) else $error("logical port one mapping wrong");
   property p_power; s_settled |-> hub_characteristics[1:0] == {1'b0, !shared_power_switch_flag}; endproperty
   a_power: assert property (p_power) else $error("power mode field wrong");
   property p_oc; s_settled |-> hub_characteristics[4:3] == hub_characteristics[1:0]; endproperty
   a_oc: assert property (p_oc) else $error("overcurrent mode field wrong");
   property p_bits;
      s_settled |-> hub_characteristics[2] == part_of_composite_flag && hub_characteristics[7] == !indicators_off_flag;
   endproperty
   a_bits: assert property (p_bits) else $error("characteristic flag bits wrong");
endmodule : hcl_loader_chk
bind hcl_loader hcl_loader_chk i_chk (.sys_clk, .rst, .mem_cs_n, .mem_sck, .load_done, .vendor_identifier,
   .usable_port_mask, .port_count, .physical_of_logical_1, .part_of_composite_flag, .indicators_off_flag,
   .shared_power_switch_flag, .hub_characteristics);

// ==== verification/hcl_mem_model.sv ====
`timescale 1ns/100ps
module hcl_mem_model (
   input wire logic mem_cs_n,
   input wire logic mem_sck,
   input wire logic mem_mosi,
   input wire logic two_byte_addr,
   output logic mem_miso
);
   logic [7:0] mem [0:15];
   logic [31:0] sr = '0;
   logic [7:0] dout = '0;
   logic [15:0] adr;
   logic [7:0] cmd;
   logic drv = 1'b0;
   logic seq_err = 1'b0;
   int bits = 0;
   int reads = 0;
   int next_addr = 0;
   int hdr;
   assign hdr = two_byte_addr ? 24 : 16;
   // released line shows the inverse, so a stale bit is never read as data
   assign mem_miso = mem_cs_n ? ~drv : drv;
   always @(negedge mem_cs_n) bits = 0;
   always @(posedge mem_sck) begin
      sr = {sr[30:0], mem_mosi};
      bits = bits + 1;
      if (bits == hdr) begin
         adr = two_byte_addr ? sr[15:0] : {7'h_00, sr[11], sr[7:0]};
         cmd = two_byte_addr ? sr[23:16] : (sr[15:8] & 8'h_F7);
         if (cmd != 8'h_03 || adr != 16'(next_addr)) seq_err = 1'b1;
         next_addr = next_addr + 1;
         reads = reads + 1;
         dout = mem[adr[3:0]];
      end
   end
   always @(negedge mem_sck) begin
      if (!mem_cs_n && bits >= hdr) begin
         drv = dout[7];
         dout = {dout[6:0], 1'b0};
      end
   end
endmodule : hcl_mem_model

// ==== verification/hcl_loader_tb_top.sv ====
`timescale 1ns/100ps
module hcl_loader_tb_top;
   logic sys_clk = 0, rst = 1, two_byte_addr = 0, fuse_present = 0, high_speed = 0, mem_miso;
   logic [15:0] fuse_vendor_identifier = 16'h_1111, fuse_product_identifier = 16'h_2222;
   logic [7:0] fuse_device_release_identifier = 8'h_33;
   logic mem_cs_n, mem_sck, mem_mosi, load_done, vendor_class, accept_zero_descriptor_type;
   logic part_of_composite_flag, limit_to_12mbit, indicators_off_flag, shared_power_switch_flag;
   logic [15:0] vendor_identifier, product_identifier, hub_characteristics;
   logic [7:0] device_release_identifier, detachable_port_mask, upstream_draw_limit;
   logic [7:0] controller_current_figure, port_power_settle_time;
   logic [3:0] enabled_port_oc_filter, disabled_port_oc_filter, usable_port_mask;
   logic [3:0] physical_of_logical_1, physical_of_logical_2, physical_of_logical_3, physical_of_logical_4;
   logic [2:0] port_count;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   hcl_loader i_dut (.*);
   hcl_mem_model i_mem (.*);
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count = bad_count + 1;
         close_out();
      end
   end
   task close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checks_done = checks_done + 1;
      if (s !== e) begin
         bad_count = bad_count + 1;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task fill(input logic [103:0] v);
      for (int k = 0; k < 16; k++) i_mem.mem[k] = (k < 13) ? v[103 - 8 * k -: 8] : 8'h_FF;
   endtask : fill
   task boot(input logic tb, input logic fp, input logic hs);
      int n;
      @(posedge sys_clk);
      #1 rst = 1;
      two_byte_addr = tb;
      fuse_present = fp;
      high_speed = hs;
      i_mem.next_addr = 0;
      i_mem.reads = 0;
      i_mem.seq_err = 0;
      repeat (12) @(posedge sys_clk);
      #1 rst = 0;
      n = 0;
      while (load_done !== 1'b1 && n < 8000) begin
         @(posedge sys_clk);
         n = n + 1;
      end
      repeat (2) @(posedge sys_clk);
      chk("load_done", 1, load_done);
   endtask : boot
   task t_ident();
      fill(104'h_D0_3412_7856_009A_FFFF_FFFF_FFFF);
      boot(0, 0, 1);
      chk("ids", 16'h_1234, vendor_identifier);
      chk("pid", 16'h_5678, product_identifier);
      chk("did", 8'h_9A, device_release_identifier);
      chk("reads", 7, 16'(i_mem.reads));
      chk("order", 0, i_mem.seq_err);
      chk("oc", 8'h_88, {enabled_port_oc_filter, disabled_port_oc_filter});
      chk("count", 4, port_count);
      chk("phys4", 4, physical_of_logical_4);
      chk("detach", 8'h_1E, detachable_port_mask);
      chk("draw", 8'h_57, upstream_draw_limit);
      chk("ctrl", 8'h_AE, controller_current_figure);
      chk("settle", 8'h_32, port_power_settle_time);
      chk("accept", 1, accept_zero_descriptor_type);
      chk("hubch", 16'h_0089, hub_characteristics);
      chk("vclass", 0, vendor_class);
      // reprogramming must not touch the live configuration
      fill(104'h_D2_CDAB_01EF_0042_3CB5_6420_1974);
      repeat (300) @(posedge sys_clk);
      chk("held", 16'h_1234, vendor_identifier);
      $display("test ident end");
   endtask : t_ident
   task t_ext();
      boot(1, 0, 0);
      chk("vid", 16'h_ABCD, vendor_identifier);
      chk("pid", 16'h_EF01, product_identifier);
      chk("did", 8'h_42, device_release_identifier);
      chk("oc", 8'h_3C, {enabled_port_oc_filter, disabled_port_oc_filter});
      chk("mask", 4'h_B, usable_port_mask);
      chk("count", 3, port_count);
      chk("map", 16'h_1240, {physical_of_logical_1, physical_of_logical_2, physical_of_logical_3,
         physical_of_logical_4});
      chk("detach", 8'h_0A, detachable_port_mask);
      chk("draw", 8'h_64, upstream_draw_limit);
      chk("ctrl", 8'h_20, controller_current_figure);
      chk("settle", 8'h_19, port_power_settle_time);
      chk("accept", 0, accept_zero_descriptor_type);
      chk("flags", 4'h_F, {part_of_composite_flag, limit_to_12mbit, indicators_off_flag,
         shared_power_switch_flag});
      chk("hubch", 16'h_0004, hub_characteristics);
      chk("reads", 13, 16'(i_mem.reads));
      chk("order", 0, i_mem.seq_err);
      $display("test ext end");
   endtask : t_ext
   task t_blank();
      fill('1);
      boot(0, 0, 0);
      chk("vclass", 1, vendor_class);
      chk("reads", 1, 16'(i_mem.reads));
      $display("test blank end");
   endtask : t_blank
   task t_fuse();
      boot(0, 1, 0);
      chk("vid", 16'h_1111, vendor_identifier);
      chk("pid", 16'h_2222, product_identifier);
      chk("did", 8'h_33, device_release_identifier);
      chk("reads", 0, 16'(i_mem.reads));
      chk("vclass", 0, vendor_class);
      chk("draw", 8'h_28, upstream_draw_limit);
      chk("ctrl", 8'h_50, controller_current_figure);
      $display("test fuse end");
   endtask : t_fuse
   initial begin
      t_ident();
      t_ext();
      t_blank();
      t_fuse();
      close_out();
   end
endmodule : hcl_loader_tb_top
